// File: gudc_defs.vh
`ifndef GUDC_DEFS_VH
`define GUDC_DEFS_VH

// count width and range limits
`define GUDC_CNT_W        31
`define GUDC_CNT_MAX      31'h7FFFFFFF
`define GUDC_CNT_ZERO     31'h00000000
// preset default
`define GUDC_PRESET_RST   31'h00002710
// operation setting codes
`define GUDC_OP_W         3
`define GUDC_OP_ON        3'h1
`define GUDC_OP_OFF       3'h5
// operator command codes
`define GUDC_CMD_CANCEL   1'h0
`define GUDC_CMD_ACT      1'h1

`endif

// File: gudc_edge_sync.v
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser followed by a rising edge detector
module gudc_edge_sync (
    input  wire CLK,
    input  wire RST_N,
    input  wire din,
    output wire level,
    output wire rise
);
    reg meta_reg;
    reg sync_reg;
    reg last_reg;

    // first stage feeds only the second stage
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise  = sync_reg & ~last_reg;
endmodule

`default_nettype wire

// File: gudc_generic_updown_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "gudc_defs.vh"

module gudc_generic_updown_counter (
    input  wire                       CLK,
    input  wire                       RST_N,
    input  wire                       UP_PULSE_IN,
    input  wire                       DOWN_PULSE_IN,
    input  wire                       RESET_IN,
    input  wire                       LOAD_IN,
    input  wire                       RESET_CMD,
    input  wire                       LOAD_CMD,
    input  wire [`GUDC_OP_W-1:0]      OPERATION,
    input  wire [`GUDC_CNT_W-1:0]     PRESET_VALUE,
    input  wire                       NV_VALID,
    input  wire [`GUDC_CNT_W-1:0]     NV_COUNT,
    output reg  [`GUDC_CNT_W-1:0]     COUNT_VALUE,
    output reg                        AT_OR_ABOVE_PRESET,
    output reg                        COUNT_AT_ZERO,
    output reg                        NV_WRITE,
    output reg  [`GUDC_CNT_W-1:0]     NV_WDATA
);
    // restore sequence states
    localparam ST_WAIT = 1'b0;
    localparam ST_RUN  = 1'b1;

    // synchronised pin views
    wire                   up_rise;
    wire                   down_rise;
    wire                   reset_lvl;
    wire                   load_lvl;

    // decoded requests, steps and status
    wire                   enabled;
    wire                   restored;
    wire                   cmd_reset;
    wire                   cmd_load;
    wire                   reset_req;
    wire                   load_req;
    wire                   up_only;
    wire                   down_only;
    wire                   at_max;
    wire                   at_zero;
    wire                   up_step;
    wire                   down_step;
    wire [`GUDC_CNT_W-1:0] count_inc;
    wire [`GUDC_CNT_W-1:0] count_dec;
    wire                   preset_hit;
    wire                   zero_hit;
    wire                   count_moves;

    // count and restore state
    reg  [`GUDC_CNT_W-1:0] count_reg;
    reg  [`GUDC_CNT_W-1:0] count_next;
    reg                    state_reg;
    reg                    state_next;

    // pins arrive from outside the clock domain
    gudc_edge_sync u_up (
        .CLK   (CLK),
        .RST_N (RST_N),
        .din   (UP_PULSE_IN),
        .level (),
        .rise  (up_rise)
    );

    gudc_edge_sync u_down (
        .CLK   (CLK),
        .RST_N (RST_N),
        .din   (DOWN_PULSE_IN),
        .level (),
        .rise  (down_rise)
    );

    gudc_edge_sync u_reset (
        .CLK   (CLK),
        .RST_N (RST_N),
        .din   (RESET_IN),
        .level (reset_lvl),
        .rise  ()
    );

    gudc_edge_sync u_load (
        .CLK   (CLK),
        .RST_N (RST_N),
        .din   (LOAD_IN),
        .level (load_lvl),
        .rise  ()
    );

    // any code other than on counts as off, the safe reading
    assign enabled = (OPERATION == `GUDC_OP_ON);

    // commands are already on this clock and need no sync
    assign cmd_reset = (RESET_CMD == `GUDC_CMD_ACT);
    assign cmd_load  = (LOAD_CMD == `GUDC_CMD_ACT);

    // either source forces the count
    assign reset_req = cmd_reset || reset_lvl;
    assign load_req  = cmd_load || load_lvl;

    // an edge on one side only; two at once cancel out
    assign up_only   = up_rise && !down_rise;
    assign down_only = down_rise && !up_rise;

    // range ends, checked before stepping so the count never wraps
    assign at_max  = (count_reg == `GUDC_CNT_MAX);
    assign at_zero = (count_reg == `GUDC_CNT_ZERO);

    // a step is taken only inside the range
    assign up_step   = up_only && !at_max;
    assign down_step = down_only && !at_zero;

    // one incrementer and one decrementer, picked in the chain below
    assign count_inc = count_reg + 31'h00000001;
    assign count_dec = count_reg - 31'h00000001;

    // restore done once the retained value has been taken over
    assign restored = (state_reg == ST_RUN);

    // restore sequence: wait for the store, then run for good
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_WAIT: begin
                if (NV_VALID) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                state_next = ST_RUN;
            end
            default: begin
                state_next = ST_WAIT;
            end
        endcase
    end

    // next count, priority reset > load > counting
    always @* begin
        count_next = count_reg;
        if (!restored) begin
            // take over the retained value once after each reset
            if (NV_VALID) begin
                count_next = NV_COUNT;
            end
        end else if (enabled) begin
            if (reset_req) begin
                count_next = `GUDC_CNT_ZERO;
            end else if (load_req) begin
                count_next = PRESET_VALUE;
            end else if (up_step) begin
                count_next = count_inc;
            end else if (down_step) begin
                count_next = count_dec;
            end else begin
                count_next = count_reg;
            end
        end
    end

    // status from the value about to be stored, so both move together
    assign preset_hit = enabled && (count_next >= PRESET_VALUE);
    assign zero_hit   = enabled && (count_next == `GUDC_CNT_ZERO);

    // write through only on change, to spare store endurance
    assign count_moves = restored && (count_next != count_reg);

    // restore state survives until the next reset
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= ST_WAIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // count state
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            count_reg <= `GUDC_CNT_ZERO;
        end else begin
            count_reg <= count_next;
        end
    end

    // retained-store write port; data follows the count every cycle
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            NV_WRITE <= 1'b0;
            NV_WDATA <= `GUDC_CNT_ZERO;
        end else begin
            NV_WRITE <= count_moves;
            NV_WDATA <= count_next;
        end
    end

    // status outputs registered with the count
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            COUNT_VALUE        <= `GUDC_CNT_ZERO;
            AT_OR_ABOVE_PRESET <= 1'b0;
            COUNT_AT_ZERO      <= 1'b0;
        end else begin
            COUNT_VALUE        <= count_next;
            AT_OR_ABOVE_PRESET <= preset_hit;
            COUNT_AT_ZERO      <= zero_hit;
        end
    end
endmodule

`default_nettype wire

// File: gudc_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "gudc_defs.vh"
module gudc_chk_sva (
    input wire        CLK,
    input wire        RST_N,
    input wire        RESET_IN,
    input wire        LOAD_IN,
    input wire        RESET_CMD,
    input wire        LOAD_CMD,
    input wire        AT_OR_ABOVE_PRESET,
    input wire        COUNT_AT_ZERO,
    input wire        NV_WRITE,
    input wire [2:0]  OPERATION,
    input wire [30:0] PRESET_VALUE,
    input wire [30:0] COUNT_VALUE,
    input wire [30:0] NV_WDATA
);
    // pin requests pass two sync flops, hence the repeats
    wire op_on = OPERATION == `GUDC_OP_ON;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    property p_zero; $past(RST_N) && $past(op_on) && $stable(COUNT_VALUE) |->
        COUNT_AT_ZERO == (COUNT_VALUE == 31'h0); endproperty
    a_zero: assert property (p_zero) else $error("zero flag");
    property p_pre; $past(RST_N) && $past(op_on) && $stable(COUNT_VALUE) &&
        $stable(PRESET_VALUE) |-> AT_OR_ABOVE_PRESET == (COUNT_VALUE >= PRESET_VALUE); endproperty
    a_pre: assert property (p_pre) else $error("preset flag");
    property p_nvw; NV_WRITE |-> NV_WDATA == COUNT_VALUE && $changed(COUNT_VALUE); endproperty
    a_nvw: assert property (p_nvw) else $error("store write");
    property p_rcmd; RESET_CMD && op_on |-> ##[1:2] COUNT_VALUE == 31'h0; endproperty
    a_rcmd: assert property (p_rcmd) else $error("reset cmd");
    property p_lcmd; LOAD_CMD && !RESET_CMD && !RESET_IN && op_on |->
        ##[1:2] COUNT_VALUE == PRESET_VALUE; endproperty
    a_lcmd: assert property (p_lcmd) else $error("load cmd");
    property p_lin; (LOAD_IN && !RESET_IN && op_on)[*5] |->
        COUNT_VALUE == PRESET_VALUE; endproperty
    a_lin: assert property (p_lin) else $error("load pin");
    property p_rin; (RESET_IN && op_on)[*5] |-> COUNT_VALUE == 31'h0; endproperty
    a_rin: assert property (p_rin) else $error("reset pin");
    property p_off; !$past(op_on) && !$past(op_on, 2) |->
        $stable(COUNT_VALUE) && !COUNT_AT_ZERO && !AT_OR_ABOVE_PRESET; endproperty
    a_off: assert property (p_off) else $error("disabled");
endmodule
bind gudc_generic_updown_counter gudc_chk_sva u_chk (.*);
`default_nettype wire

// File: gudc_nv_model.sv
`timescale 1ns/1ps
`default_nettype none
module gudc_nv_model (
    input  wire        CLK,
    input  wire        RST_N,
    input  wire        NV_WRITE,
    input  wire [30:0] NV_WDATA,
    output reg         NV_VALID,
    output reg  [30:0] NV_COUNT
);
    // content outlives reset; only the valid flag drops
    initial NV_COUNT = 31'h00000005;
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) NV_VALID <= 1'b0;
        else NV_VALID <= 1'b1;
    end
    always @(posedge CLK) if (NV_WRITE) NV_COUNT <= NV_WDATA;
endmodule
`default_nettype wire

// File: gudc_generic_updown_counter_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "gudc_defs.vh"
module gudc_generic_updown_counter_tb;
    reg        clk = 1'b0, rst_n = 1'b0, up = 1'b0, dn = 1'b0, ri = 1'b0, li = 1'b0;
    reg        rc = 1'b0, lc = 1'b0;
    reg [2:0]  op = 3'h1;
    reg [30:0] pre = `GUDC_PRESET_RST, exp;
    reg [31:0] seed = 32'h00016A4B;
    wire       nvv, nvw, aop, zr;
    wire [30:0] nvc, cnt, nvd;
    integer    bad_count = 0, samples_checked = 0;
    always #2.5 clk = ~clk;
    gudc_generic_updown_counter uut (.CLK(clk), .RST_N(rst_n), .UP_PULSE_IN(up),
        .DOWN_PULSE_IN(dn), .RESET_IN(ri), .LOAD_IN(li), .RESET_CMD(rc), .LOAD_CMD(lc),
        .OPERATION(op), .PRESET_VALUE(pre), .NV_VALID(nvv), .NV_COUNT(nvc),
        .COUNT_VALUE(cnt), .AT_OR_ABOVE_PRESET(aop), .COUNT_AT_ZERO(zr),
        .NV_WRITE(nvw), .NV_WDATA(nvd));
    gudc_nv_model u_nv (.CLK(clk), .RST_N(rst_n), .NV_WRITE(nvw), .NV_WDATA(nvd),
        .NV_VALID(nvv), .NV_COUNT(nvc));
    // xorshift keeps the random walk repeatable
    function [31:0] xs(input [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    // saturating at both ends, opposing edges cancel
    function [30:0] step(input [30:0] c, input u, input d);
        step = (u == d) ? c : u ? ((c == `GUDC_CNT_MAX) ? c : c + 31'h1)
            : ((c == 31'h0) ? c : c - 31'h1);
    endfunction
    task chk(input [31:0] got, input [31:0] want);
        samples_checked = samples_checked + 1;
        if (got !== want) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask
    task look;
        chk(cnt, exp);
        chk(zr, exp == 31'h0);
        chk(aop, exp >= pre);
    endtask
    // pin high one cycle, low after, then the sync latency
    task pulse(input u, input d);
        @(negedge clk) {up, dn} = {u, d};
        @(negedge clk) {up, dn} = 2'h0;
        repeat (3) @(negedge clk);
        exp = step(exp, u, d);
    endtask
    task summarize;
        $display("checked %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #20000 bad_count = bad_count + 1;
        summarize;
    end
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        exp = 31'h5;
        look;
        repeat (40) begin
            seed = xs(seed);
            pulse(seed[0], seed[1]);
            look;
        end
        @(negedge clk) {rc, lc} = 2'h3;
        @(negedge clk) {rc, lc} = 2'h0;
        repeat (3) @(negedge clk);
        exp = 31'h0;
        look;
        pulse(1'b0, 1'b1);
        look;
        pre = 31'h7FFFFFFE;
        @(negedge clk) lc = 1'b1;
        @(negedge clk) lc = 1'b0;
        repeat (3) @(negedge clk);
        exp = pre;
        look;
        pulse(1'b1, 1'b0);
        pulse(1'b1, 1'b0);
        look;
        li = 1'b1;
        pulse(1'b1, 1'b0);
        exp = pre;
        look;
        ri = 1'b1;
        repeat (5) @(negedge clk);
        {ri, li} = 2'h0;
        repeat (3) @(negedge clk);
        exp = 31'h0;
        look;
        op = `GUDC_OP_OFF;
        pre = 31'h0;
        pulse(1'b1, 1'b0);
        exp = 31'h0;
        chk(cnt, 31'h0);
        chk(zr, 1'b0);
        chk(aop, 1'b0);
        op = `GUDC_OP_ON;
        pulse(1'b1, 1'b0);
        exp = 31'h1;
        look;
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        look;
        summarize;
    end
endmodule
`default_nettype wire
